// ===== led_host_pkg.sv
package led_host_pkg;

    localparam int DIGITS = 8;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int NIB_W = 4;
    localparam int DP_BIT = 7;
    localparam int SYNC_LEN = 3;
    localparam int RAM_IDX_LSB = 2;

    // APB map
    localparam int APB_AW = 8;
    localparam logic [7:0] OFF_CFG = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_RAM_A = 8'h20;
    localparam logic [7:0] OFF_RAM_B = 8'h40;
    localparam logic [7:0] RAM_WIN_MASK = 8'hE3;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // Control word, field order matches the data pins 7..0
    typedef struct packed {
        logic seq_update_flag;
        logic hex_scheme_sel;
        logic no_decode_sel;
        logic power_down_bit;
        logic bank_sel;
        logic [ADDR_W-1:0] addr;
    } ctrl_word_t;

    localparam ctrl_word_t CTRL_RESET = 8'h10;

    typedef struct packed {
        logic mode_sel;
        logic [DATA_W-1:0] data;
        logic [ADDR_W-1:0] addr;
    } pin_bus_t;

    typedef enum logic [1:0] {
        FUNC_LOW = 2'b00,
        FUNC_HIGH = 2'b01,
        FUNC_FLOAT = 2'b10
    } func_level_t;

    typedef enum logic [1:0] {
        ST_SINGLE = 2'b00,
        ST_FILL = 2'b01,
        ST_LOCKED = 2'b10
    } update_state_t;

    typedef struct packed {
        logic [1:0] state;
        logic [ADDR_W-1:0] fill_idx;
        logic display_on;
        logic power_on;
        logic hex_decode;
    } status_word_t;

endpackage

// ===== led_host_port.sv
`timescale 1ns/1ps
// Contract
// - Control variant captures data on write strobe rising edge; host holds inputs.
// - Select high loads control register, select low loads display RAM.
// - Control bit 4 high runs normally, low stops scan and blanks display.
// - RAM write stores data inputs 0..6 as display bits 0..6; the direct variant stores only inputs 0..3 and clears bits 4..6.
// - Control write, sequential flag low: inputs 2..0 give digit address.
// - Control bit 3 selects bank A high, bank B low, decoded modes only.
// - Direct variant has no control register; each write stores to RAM.
// - Direct variant decodes three address inputs to one of eight words.
// - Direct variant decimal point input is active low; low lights it.
// - Direct function input: high hex, float Code B, low shuts down.
// - Control bit 5 high selects no-decode, low selects decoded display.
// - Control bit 6 high selects hexadecimal, low selects Code B.
// - Control bit 7 is sequential flag; on RAM writes it is decimal point.
module led_host_port
    import led_host_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic write_strobe,
    input wire logic mode_sel,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic [ADDR_W-1:0] digit_addr,
    input wire logic [1:0] tri_level_function,
    input wire logic [ADDR_W-1:0] scan_addr,
    output logic [DATA_W-1:0] scan_data,
    output logic display_on,
    output logic power_on,
    output logic no_decode,
    output logic hex_decode
);

    ////////////////////////////////////////////////////////////////////////////////
    logic [SYNC_LEN-1:0] strobe_sync;
    logic strobe_level;
    logic write_pulse;
    pin_bus_t pins_s1, pins_s2, pins_s3;
    logic [1:0] func_s1, func_s2, func_s3;
    func_level_t func_level;
    logic direct;
    ctrl_word_t ctrl;
    update_state_t state;
    logic [ADDR_W-1:0] fill_idx;
    logic ctrl_write, ram_write, wr_bank_a;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_byte;
    logic [DATA_W-2:0] ram_a [DIGITS];
    logic [DATA_W-2:0] ram_b [DIGITS];
    logic dp_mem [DIGITS];
    logic [ADDR_W-1:0] last_addr;
    logic last_dp;
    logic show_bank_a;
    logic next_power_on;
    logic apb_setup, apb_write;
    logic [ADDR_W-1:0] ram_idx;
    status_word_t status;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; data rides a pipe of equal length so it lines up with
    // the strobe sample. Hold of zero means data is taken as the edge is seen.
    always_ff @(posedge clk) begin
        if (rst) begin
            strobe_sync <= '0;
            strobe_level <= 1'b0;
        end else begin
            strobe_sync <= {strobe_sync[SYNC_LEN-2:0], write_strobe};
            if (strobe_sync[1] == strobe_sync[2]) begin
                strobe_level <= strobe_sync[2];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pins_s1 <= '0;
            pins_s2 <= '0;
            pins_s3 <= '0;
        end else begin
            pins_s1 <= '{mode_sel: mode_sel, data: data_in, addr: digit_addr};
            pins_s2 <= pins_s1;
            pins_s3 <= pins_s2;
        end
    end

    assign write_pulse = strobe_sync[1] & strobe_sync[2] & ~strobe_level;

    // Float cannot be sensed, so the pad cell reports it as a code
    always_ff @(posedge clk) begin
        if (rst) begin
            // Pipe starts at the float code so no false shutdown follows reset
            func_s1 <= FUNC_FLOAT;
            func_s2 <= FUNC_FLOAT;
            func_s3 <= FUNC_FLOAT;
            func_level <= FUNC_FLOAT;
        end else begin
            func_s1 <= tri_level_function;
            func_s2 <= func_s1;
            func_s3 <= func_s2;
            if (func_s2 == func_s3) begin
                func_level <= func_level_t'(func_s3);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Write steering
    assign ctrl_write = write_pulse & ~direct & pins_s3.mode_sel;
    assign ram_write = write_pulse & (direct | (~pins_s3.mode_sel & (state != ST_LOCKED)));
    assign wr_bank_a = direct | ctrl.no_decode_sel | ctrl.bank_sel;

    always_comb begin
        wr_addr = ctrl.addr;
        if (direct) begin
            wr_addr = pins_s3.addr;
        end else if (state == ST_FILL) begin
            wr_addr = fill_idx;
        end
        wr_byte = pins_s3.data;
        if (direct) begin
            wr_byte = '0;
            wr_byte[NIB_W-1:0] = pins_s3.data[NIB_W-1:0];
            wr_byte[DP_BIT] = ~pins_s3.data[DP_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl <= CTRL_RESET;
        end else if (ctrl_write) begin
            ctrl <= ctrl_word_t'(pins_s3.data);
        end
    end

    // Sequential fill of all eight digits, then further RAM writes are dropped
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_SINGLE;
            fill_idx <= '0;
        end else if (ctrl_write) begin
            fill_idx <= '0;
            state <= pins_s3.data[DP_BIT] ? ST_FILL : ST_SINGLE;
        end else if (ram_write && !direct && state == ST_FILL) begin
            fill_idx <= fill_idx + 1'b1;
            if (fill_idx == ADDR_W'(DIGITS - 1)) begin
                state <= ST_LOCKED;
            end
        end
    end

    // Decimal point kept apart so it shows on either bank
    always_ff @(posedge clk) begin
        if (ram_write) begin
            dp_mem[wr_addr] <= wr_byte[DP_BIT];
            if (wr_bank_a) begin
                ram_a[wr_addr] <= wr_byte[DATA_W-2:0];
            end else begin
                ram_b[wr_addr] <= wr_byte[DATA_W-2:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            last_addr <= '0;
            last_dp <= 1'b0;
        end else if (ram_write) begin
            last_addr <= wr_addr;
            last_dp <= wr_byte[DP_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs toward scan and decode logic
    assign show_bank_a = direct | ctrl.no_decode_sel | ctrl.bank_sel;
    assign next_power_on = direct ? (func_level != FUNC_LOW) : ctrl.power_down_bit;

    always_ff @(posedge clk) begin
        if (rst) begin
            scan_data <= '0;
            display_on <= 1'b0;
            power_on <= 1'b0;
            no_decode <= 1'b0;
            hex_decode <= 1'b0;
        end else begin
            scan_data <= {dp_mem[scan_addr],
                          show_bank_a ? ram_a[scan_addr] : ram_b[scan_addr]};
            power_on <= next_power_on;
            display_on <= next_power_on & (direct | (state != ST_FILL));
            no_decode <= ~direct & ctrl.no_decode_sel;
            hex_decode <= direct ? (func_level == FUNC_HIGH) : ctrl.hex_scheme_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave, no wait states; read data staged during setup
    assign pready = 1'b1;
    assign apb_setup = psel & ~penable;
    assign apb_write = psel & penable & pwrite;
    assign ram_idx = paddr[RAM_IDX_LSB +: ADDR_W];
    assign status = '{state: state, fill_idx: fill_idx, display_on: display_on,
                      power_on: power_on, hex_decode: hex_decode};

    always_ff @(posedge clk) begin
        if (rst) begin
            direct <= 1'b0;
        end else if (apb_write && paddr == OFF_CFG) begin
            direct <= pwdata[0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= WORD_ZERO;
            pslverr <= 1'b0;
        end else if (apb_setup) begin
            prdata <= WORD_ZERO;
            pslverr <= 1'b0;
            if (paddr == OFF_CFG) begin
                prdata[0] <= direct;
            end else if (paddr == OFF_CTRL) begin
                prdata[DATA_W-1:0] <= ctrl;
            end else if (paddr == OFF_STATUS) begin
                prdata[$bits(status_word_t)-1:0] <= status;
            end else if ((paddr & RAM_WIN_MASK) == OFF_RAM_A) begin
                prdata[DATA_W-1:0] <= {dp_mem[ram_idx], ram_a[ram_idx]};
            end else if ((paddr & RAM_WIN_MASK) == OFF_RAM_B) begin
                prdata[DATA_W-1:0] <= {dp_mem[ram_idx], ram_b[ram_idx]};
            end else begin
                pslverr <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_CTRL_CAPTURE: assert property (
        ctrl_write |=> ctrl == ctrl_word_t'($past(pins_s3.data)))
        else $error("Control word not captured from data pins");

    AST_RAM_KEEPS_CTRL: assert property (
        (write_pulse && !direct && !pins_s3.mode_sel) |=> $stable(ctrl))
        else $error("Display write altered control word");

    AST_POWER_DOWN: assert property (
        (!direct && !ctrl.power_down_bit) |=> (!display_on && !power_on))
        else $error("Display not blanked in power down");

    AST_DP_STORED: assert property (
        ram_write |=> dp_mem[last_addr] == last_dp)
        else $error("Display RAM word not stored");

    AST_SINGLE_ADDR: assert property (
        (ram_write && !direct && state == ST_SINGLE) |-> wr_addr == ctrl.addr)
        else $error("Single digit write at wrong address");

    AST_BANK_B: assert property (
        (ram_write && !direct && !ctrl.no_decode_sel && !ctrl.bank_sel) |-> !wr_bank_a)
        else $error("Bank B write went to bank A");

    AST_DIRECT_NO_CTRL: assert property (
        (direct && write_pulse) |=> $stable(ctrl))
        else $error("Direct variant changed control word");

    AST_DIRECT_ADDR: assert property (
        (direct && write_pulse) |-> (ram_write && wr_addr == pins_s3.addr))
        else $error("Direct write missed its address");

    AST_DIRECT_DP: assert property (
        (direct && ram_write) |-> wr_byte[DP_BIT] != pins_s3.data[DP_BIT])
        else $error("Decimal point polarity wrong");

    AST_FUNC_LOW: assert property (
        (direct && func_level == FUNC_LOW) |=> (!power_on && !display_on))
        else $error("Function low did not shut down");

    AST_NO_DECODE: assert property (
        (!direct && ctrl.no_decode_sel) |=> no_decode)
        else $error("No-decode select not shown");

    AST_HEX: assert property (
        (!direct && $stable(ctrl) && !$stable(ctrl.hex_scheme_sel)) or
        (!direct |=> hex_decode == $past(ctrl.hex_scheme_sel)))
        else $error("Hex scheme select not shown");

    AST_FILL_START: assert property (
        // Blank lags the state change by one edge
        (ctrl_write && pins_s3.data[DP_BIT]) |=> (state == ST_FILL && fill_idx == '0)
        ##1 !display_on)
        else $error("Sequential update did not start blanked");

    AST_PULSE_ONE: assert property (
        write_pulse |=> !write_pulse [*2])
        else $error("Write pulse longer than one cycle");

endmodule // led_host_port

// ===== host_writer.sv
`timescale 1ns/1ps
module host_writer
    import led_host_pkg::*;
(
    input wire logic clk,
    output logic write_strobe,
    output logic mode_sel,
    output logic [DATA_W-1:0] data_in,
    output logic [ADDR_W-1:0] digit_addr
);
    initial begin
        write_strobe = 1'b0;
        mode_sel = 1'b0;
        data_in = 8'h00;
        digit_addr = 3'h0;
    end
    ////////////////////////////////////////////////////////////////
    // One write cycle, 250 ns setup, 200 ns strobe, gap after
    task automatic put(input logic m, input logic [7:0] d, input logic [2:0] a);
        @(posedge clk);
        mode_sel <= m;
        data_in <= d;
        digit_addr <= a;
        repeat (5) @(posedge clk);
        write_strobe <= 1'b1;
        repeat (2) @(posedge clk);
        // Hold over: pins no longer carry the written value
        mode_sel <= ~m;
        data_in <= ~d;
        digit_addr <= ~a;
        repeat (2) @(posedge clk);
        write_strobe <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
endmodule // host_writer

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top
    import led_host_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic write_strobe;
    logic mode_sel;
    logic [7:0] data_in;
    logic [2:0] digit_addr;
    logic [1:0] tri_level_function = 2'h1;
    logic [2:0] scan_addr = 3'h0;
    logic [7:0] scan_data;
    logic display_on;
    logic power_on;
    logic no_decode;
    logic hex_decode;
    logic [31:0] rd;
    logic er;
    int errors = 0;
    int comparisons = 0;
    // Rows: control word, RAM data, read offset, expected word
    logic [31:0] rows [4] = '{32'h1885_2085, 32'h5709_5C09, 32'h337E_2C7E, 32'h5D8F_348F};
    always #25 clk = ~clk;
    led_host_port dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .write_strobe(write_strobe),
        .mode_sel(mode_sel), .data_in(data_in), .digit_addr(digit_addr),
        .tri_level_function(tri_level_function), .scan_addr(scan_addr),
        .scan_data(scan_data), .display_on(display_on), .power_on(power_on),
        .no_decode(no_decode), .hex_decode(hex_decode));
    host_writer host_u (.clk(clk), .write_strobe(write_strobe), .mode_sel(mode_sel),
        .data_in(data_in), .digit_addr(digit_addr));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        // Idle edge first, so a release is never overwritten in one step
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // No wait count assumed; only the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
        chk(32'(er), 32'h0000_0000);
    endtask
    task automatic summarize();
        if (errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge clk);
        errors++;
        summarize();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        rdchk(OFF_CTRL, 32'(CTRL_RESET));
        chk(32'(display_on), 32'h0000_0001);
        chk(32'(pready), 32'h0000_0001);
        apb(1'b1, OFF_CTRL, 32'h0000_00FF);
        rdchk(OFF_CTRL, 32'(CTRL_RESET));
        for (int i = 0; i < 4; i++) begin
            host_u.put(1'b1, rows[i][31:24], 3'h0);
            host_u.put(1'b0, rows[i][23:16], 3'h0);
            rdchk(OFF_CTRL, 32'(rows[i][31:24]));
            rdchk(rows[i][15:8], 32'(rows[i][7:0]));
            chk(32'({power_on, no_decode, hex_decode}), 32'({2'b11, rows[i][30]}) - 32'(!rows[i][29] * 2));
            chk(32'(hex_decode), 32'(rows[i][30]));
            scan_addr <= rows[i][26:24];
            repeat (2) @(posedge clk);
            chk(32'(scan_data), 32'(rows[i][7:0]));
        end
        // Fill of all eight digits, then a ninth write that must be dropped
        host_u.put(1'b1, 8'h98, 3'h0);
        chk(32'(display_on), 32'h0000_0000);
        for (int i = 0; i < 8; i++) begin
            host_u.put(1'b0, 8'(i), 3'h0);
        end
        host_u.put(1'b0, 8'h0F, 3'h0);
        chk(32'(display_on), 32'h0000_0001);
        rdchk(OFF_RAM_A, 32'h0000_0000);
        rdchk(OFF_RAM_A + 8'h1C, 32'h0000_0007);
        apb(1'b0, OFF_STATUS, 32'h0000_0000);
        chk(32'(rd[7:6]), 32'h0000_0002);
        host_u.put(1'b1, 8'h08, 3'h0);
        chk(32'({power_on, display_on}), 32'h0000_0000);
        apb(1'b0, 8'h0C, 32'h0000_0000);
        chk(32'(er), 32'h0000_0001);
        apb(1'b0, 8'h21, 32'h0000_0000);
        chk(32'(er), 32'h0000_0001);
        // Direct variant: three function levels, then two stores
        apb(1'b1, OFF_CFG, 32'h0000_0001);
        tri_level_function <= FUNC_HIGH;
        repeat (8) @(posedge clk);
        chk(32'({power_on, hex_decode}), 32'h0000_0003);
        tri_level_function <= FUNC_FLOAT;
        repeat (8) @(posedge clk);
        chk(32'({power_on, hex_decode}), 32'h0000_0002);
        tri_level_function <= FUNC_LOW;
        repeat (8) @(posedge clk);
        chk(32'({power_on, display_on}), 32'h0000_0000);
        tri_level_function <= FUNC_HIGH;
        host_u.put(1'b1, 8'h05, 3'h6);
        host_u.put(1'b0, 8'h83, 3'h1);
        rdchk(OFF_RAM_A + 8'h18, 32'h0000_0085);
        rdchk(OFF_RAM_A + 8'h04, 32'h0000_0003);
        rdchk(OFF_CTRL, 32'h0000_0008);
        summarize();
    end
endmodule // tb_top
